// ---- bench/crx_lane_receiver_bench.sv ----
// Self-checking bench for the camera lane receiver, with the sensor model on its lane pins.
// Assumes a 40 MHz clock and a byte clock of 200 ns made by the model within bursts only.
`timescale 1ns/1ps
module crx_lane_receiver_bench;
  typedef struct {
    logic [2:0] n;
    logic cont;
    logic [5:0] dt;
    logic [1:0] vc;
    logic [15:0] wc;
    logic fr;
  } crx_row_t;
  logic clk, rst, cont_clk, rdy, bclk, clp_p, clp_n;
  logic [2:0] lane_cnt;
  logic [3:0] lp_p, lp_n, o_term_en, o_lane_hs;
  logic [31:0] hs;
  logic [7:0] o_data;
  logic [1:0] o_short_vc;
  logic [5:0] o_short_dt;
  logic [15:0] o_short_data;
  logic o_valid, o_clk_term_en, o_short_valid, o_in_frame, o_ecc_err, o_ecc_corr;
  logic o_crc_err, o_sot_err, o_sot_sync_err, o_ovf, o_cfg_err;
  logic [7:0] tx[$], pay[$], got[$];
  logic [23:0] sh;
  logic [5:0] flags;
  int sh_n, compares, bad_count, cyc;
  crx_row_t rows[5] = '{'{3'h1, 1'b0, 6'h00, 2'h1, 16'h1234, 1'b1}, '{3'h2, 1'b0, 6'h2A, 2'h0, 16'h0006, 1'b1},
    '{3'h4, 1'b1, 6'h10, 2'h2, 16'h0009, 1'b1}, '{3'h4, 1'b0, 6'h0F, 2'h3, 16'hABCD, 1'b1},
    '{3'h1, 1'b1, 6'h2B, 2'h0, 16'h0005, 1'b1}};
  crx_sensor_model sen (.i_clk(clk), .o_lp_p(lp_p), .o_lp_n(lp_n), .o_clk_lp_p(clp_p), .o_clk_lp_n(clp_n),
    .o_byte_clk(bclk), .o_hs_byte(hs));
  crx_lane_receiver DUT (.i_clk(clk), .i_rst(rst), .i_cont_clk(cont_clk), .i_lane_cnt(lane_cnt), .i_lp_p(lp_p),
    .i_lp_n(lp_n), .i_clk_lp_p(clp_p), .i_clk_lp_n(clp_n), .i_byte_clk(bclk), .i_hs_byte(hs), .i_ready(rdy),
    .o_data(o_data), .o_valid(o_valid), .o_term_en(o_term_en), .o_clk_term_en(o_clk_term_en),
    .o_lane_hs(o_lane_hs), .o_short_valid(o_short_valid), .o_short_vc(o_short_vc), .o_short_dt(o_short_dt),
    .o_short_data(o_short_data), .o_in_frame(o_in_frame), .o_ecc_err(o_ecc_err), .o_ecc_corr(o_ecc_corr),
    .o_crc_err(o_crc_err), .o_sot_err(o_sot_err), .o_sot_sync_err(o_sot_sync_err), .o_ovf(o_ovf),
    .o_cfg_err(o_cfg_err));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Pulses are caught here so that checks need not hit the exact cycle
  always @(posedge clk) begin
    cyc++;
    if (o_valid === 1'b1 && rdy === 1'b1) got.push_back(o_data);
    if (o_short_valid === 1'b1) begin
      sh_n++;
      sh = {o_short_vc, o_short_dt, o_short_data};
    end
    flags = flags | {o_ecc_err, o_ecc_corr, o_crc_err, o_sot_err, o_sot_sync_err, o_ovf};
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_q;
    chk(got.size(), pay.size());
    foreach (pay[i]) if (i < got.size()) chk(got[i], pay[i]);
  endtask
  // Header, ECC over 24 bits, payload and reflected CRC, all worked out here
  task automatic mk(input logic [1:0] vc, input logic [5:0] dt, input logic [15:0] wc, input logic [23:0] flip);
    logic [23:0] h;
    logic [5:0] e;
    logic [15:0] c;
    logic [7:0] b;
    h = {wc, vc, dt};
    e = 6'h00;
    pay.delete();
    for (int i = 0; i < 24; i++) if (h[i]) e ^= crx_pkg::ECC_COL[i];
    h ^= flip;
    tx = '{h[7:0], h[15:8], h[23:16], {2'h0, e}};
    if (dt > crx_pkg::SHORT_DT_MAX) begin
      c = crx_pkg::CRC_SEED;
      for (int i = 0; i < wc; i++) begin
        b = 8'(i * 37 + 5);
        pay.push_back(b);
        tx.push_back(b);
        for (int j = 0; j < 8; j++) c = (c[0] ^ b[j]) ? ((c >> 1) ^ crx_pkg::CRC_POLY) : (c >> 1);
      end
      tx.push_back(c[7:0]);
      tx.push_back(c[15:8]);
    end
  endtask
  task automatic burst(input logic [2:0] n, input logic cont, input logic [7:0] sb);
    logic [3:0] m;
    m = (n == 3'h4) ? 4'hF : (n == 3'h2) ? 4'h3 : (n == 3'h1) ? 4'h1 : 4'h7;
    lane_cnt = n;
    cont_clk = cont;
    got.delete();
    sh_n = 0;
    flags = 6'h00;
    sen.enter(m, cont);
    if (m != 4'h7) begin
      chk(o_term_en, m);
      chk(o_lane_hs, m);
      chk(o_clk_term_en, 1'b1);
    end
    sen.send(m, tx, sb);
    repeat (16) @(posedge clk);
    sen.leave(m, cont);
    chk(o_term_en, 4'h0);
    chk(o_clk_term_en, cont);
  endtask
  task end_of_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rdy = 1'b1;
    cont_clk = 1'b0;
    lane_cnt = 3'h1;
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk);
    #2;
    chk({o_term_en, o_valid, o_short_valid, o_in_frame, o_clk_term_en}, 32'h0);
    foreach (rows[r]) begin
      mk(rows[r].vc, rows[r].dt, rows[r].wc, 24'h0);
      burst(rows[r].n, rows[r].cont, crx_pkg::SYNC_BYTE);
      if (rows[r].dt <= crx_pkg::SHORT_DT_MAX) chk(sh, {rows[r].vc, rows[r].dt, rows[r].wc});
      else chk_q();
      chk(flags, 6'h00);
      chk(o_in_frame, rows[r].fr);
    end
    // Sink stalls mid-payload; the two-entry buffer must hold every byte
    mk(2'h0, 6'h2A, 16'h0008, 24'h0);
    fork
      burst(3'h1, 1'b0, crx_pkg::SYNC_BYTE);
      begin
        repeat (80) @(posedge clk);
        #2 rdy = 1'b0;
        repeat (14) @(posedge clk);
        #2 rdy = 1'b1;
      end
    join
    chk_q();
    chk(flags, 6'h00);
    // Sink stalls past two byte strobes; the merger must flag the lost byte
    mk(2'h0, 6'h2A, 16'h0008, 24'h0);
    fork
      burst(3'h1, 1'b0, crx_pkg::SYNC_BYTE);
      begin
        repeat (70) @(posedge clk);
        #2 rdy = 1'b0;
        repeat (40) @(posedge clk);
        #2 rdy = 1'b1;
      end
    join
    chk(flags[0], 1'b1);
    mk(2'h0, 6'h2A, 16'h0004, 24'h0);
    tx[tx.size()-1] ^= 8'h01;
    burst(3'h2, 1'b0, crx_pkg::SYNC_BYTE);
    chk(flags, 6'b001000);
    mk(2'h0, 6'h02, 16'h0055, 24'h000004);
    burst(3'h1, 1'b0, crx_pkg::SYNC_BYTE);
    chk(sh, {2'h0, 6'h02, 16'h0055});
    chk(flags, 6'b110000);
    mk(2'h0, 6'h02, 16'h0055, 24'h000300);
    burst(3'h1, 1'b0, crx_pkg::SYNC_BYTE);
    chk({sh_n[7:0], 2'h0, flags}, {8'h0, 8'h20});
    mk(2'h1, 6'h03, 16'h0001, 24'h0);
    burst(3'h1, 1'b0, 8'hB9);
    chk({sh_n[7:0], 2'h0, flags}, {8'h1, 8'h04});
    burst(3'h1, 1'b0, 8'h47);
    chk({sh_n[7:0], 2'h0, flags}, {8'h0, 8'h02});
    burst(3'h3, 1'b0, crx_pkg::SYNC_BYTE);
    chk({sh_n[7:0], 7'h0, o_cfg_err}, {8'h0, 8'h1});
    // Frame end, then a long packet that must not reach the stream
    mk(2'h0, crx_pkg::DT_FE, 16'h0000, 24'h0);
    burst(3'h2, 1'b0, crx_pkg::SYNC_BYTE);
    chk(o_in_frame, 1'b0);
    mk(2'h0, 6'h2A, 16'h0004, 24'h0);
    pay.delete();
    burst(3'h2, 1'b0, crx_pkg::SYNC_BYTE);
    chk_q();
    // Reset inside a burst; LP-00 alone must not bring the lane back
    lane_cnt = 3'h1;
    sen.enter(4'h1, 1'b1);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk);
    #2;
    chk(o_term_en, 4'h0);
    sen.leave(4'h1, 1'b1);
    end_of_test();
  end
endmodule

// ---- bench/crx_sensor_model.sv ----
// Behavioural camera sensor driving the clock lane, up to four data lanes and the byte clock.
// Assumes the bench calls its tasks just after a rising edge of i_clk.
`timescale 1ns/1ps
module crx_sensor_model (
  input wire logic i_clk,
  output logic [3:0] o_lp_p,
  output logic [3:0] o_lp_n,
  output logic o_clk_lp_p,
  output logic o_clk_lp_n,
  output logic o_byte_clk,
  output logic [31:0] o_hs_byte
);
  initial begin
    o_lp_p = 4'hF;
    o_lp_n = 4'hF;
    o_clk_lp_p = 1'b1;
    o_clk_lp_n = 1'b1;
    o_byte_clk = 1'b0;
    o_hs_byte = 32'h5A5A5A5A;
  end
  ////////////////////////////////////////////////////////////////////////
  // Each line state is held five cycles, more than the receiver needs
  task automatic lp_set(input logic [3:0] m, input logic c, input logic [1:0] s);
    @(posedge i_clk);
    #2;
    for (int g = 0; g < 4; g++) if (m[g]) {o_lp_p[g], o_lp_n[g]} = s;
    if (c) {o_clk_lp_p, o_clk_lp_n} = s;
    repeat (4) @(posedge i_clk);
    #2;
  endtask
  // Burst starts from stop and keeps LP-00 throughout
  task automatic enter(input logic [3:0] m, input logic cont);
    if (!cont) begin
      lp_set(4'h0, 1'b1, crx_pkg::LP01);
      lp_set(4'h0, 1'b1, crx_pkg::LP00);
    end
    lp_set(m, 1'b0, crx_pkg::LP01);
    lp_set(m, 1'b0, crx_pkg::LP00);
  endtask
  task automatic leave(input logic [3:0] m, input logic cont);
    lp_set(m, 1'b0, crx_pkg::LP11);
    if (!cont) lp_set(4'h0, 1'b1, crx_pkg::LP11);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Byte clock runs only inside the burst; bytes change while it is low
  task automatic strobe;
    #100 o_byte_clk = 1'b1;
    #100 o_byte_clk = 1'b0;
  endtask
  task automatic send(input logic [3:0] m, input logic [7:0] q[$], input logic [7:0] sb);
    int n;
    int k;
    n = $countones(m);
    k = 0;
    for (int g = 0; g < 4; g++) o_hs_byte[8*g+:8] = m[g] ? sb : ~sb;
    strobe();
    while (k < q.size()) begin
      for (int g = 0; g < 4; g++) o_hs_byte[8*g+:8] = (g < n && k + g < q.size()) ? q[k+g] : 8'(k + g);
      k += n;
      strobe();
    end
    // Released lines must not keep the last byte
    o_hs_byte = ~o_hs_byte;
  endtask
endmodule

// ---- design/crx_lane_receiver.sv ----
// Receive front end for a camera serial link: lane states, byte merge, packet parse.
// Assumes lane pins and the byte clock are asynchronous and slow against i_clk;
// deserialised bytes change on the byte clock's falling edge.
//
// Summary of operation
// - Lane enters high-speed only after LP-11, LP-01, LP-00 in order.
// - High-speed lane stays so until LP-11 is seen.
// - Data lane termination is on during a burst of a lane within the lane count, off otherwise.
// - Clock lane uses the same entry and exit sequence.
// - Continuous or non-continuous clock lane chosen by a configuration bit.
// - Continuous clock lane counts as always high-speed.
// - Only one, two or four data lanes are accepted.
// - Data type 0x00 to 0x0F means short packet, else long.
// - Short packets mark frames and lines; long payload follows frame start.
// - Receiver is target only and never drives a lane.
// - Escape mode is not decoded.
// - Long packet: 32-bit header, word-count payload bytes, 16-bit checksum.
// - Header ECC corrects single, detects double errors, raises a flag.
// - Payload checksum mismatch raises a flag.
// - Start-of-transmission and sync errors raise flags.
`timescale 1ns/1ps
module crx_lane_receiver (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cont_clk,
  input wire logic [2:0] i_lane_cnt,
  input wire logic [3:0] i_lp_p,
  input wire logic [3:0] i_lp_n,
  input wire logic i_clk_lp_p,
  input wire logic i_clk_lp_n,
  input wire logic i_byte_clk,
  input wire logic [31:0] i_hs_byte,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic [3:0] o_term_en,
  output logic o_clk_term_en,
  output logic [3:0] o_lane_hs,
  output logic o_short_valid,
  output logic [1:0] o_short_vc,
  output logic [5:0] o_short_dt,
  output logic [15:0] o_short_data,
  output logic o_in_frame,
  output logic o_ecc_err,
  output logic o_ecc_corr,
  output logic o_crc_err,
  output logic o_sot_err,
  output logic o_sot_sync_err,
  output logic o_ovf,
  output logic o_cfg_err
);
  localparam int NL = crx_pkg::LANES;
  localparam int SW = 2 * (NL + 1) + 1 + 8 * NL;

  function automatic logic [5:0] ecc_calc(input logic [23:0] d);
    logic [5:0] p;
    p = '0;
    for (int i = 0; i < 24; i++) begin
      p = p ^ (d[i] ? crx_pkg::ECC_COL[i] : 6'h00);
    end
    return p;
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int k = 0; k < 8; k++) begin
      fb = r[0] ^ b[k];
      r = {1'b0, r[15:1]} ^ (fb ? crx_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; lanes are inputs only, nothing is driven back
  logic [SW-1:0] pin_s1_r;
  logic [SW-1:0] pin_s2_r;
  logic bclk_d_r;
  logic bclk_rise;
  logic [8*NL-1:0] hs_s;
  logic [1:0] lp_s [NL+1];
  logic [NL:0] lane_hs_raw;
  logic [NL-1:0] lane_act;
  logic [NL-1:0] lane_rx;
  logic [NL-1:0] lane_ok;
  logic [NL-1:0] sot_e;
  logic [NL-1:0] sync_e;
  logic [2:0] lane_num;
  logic clk_hs;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      bclk_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {i_byte_clk, i_clk_lp_p, i_clk_lp_n, i_lp_p, i_lp_n, i_hs_byte};
      pin_s2_r <= pin_s1_r;
      bclk_d_r <= pin_s2_r[SW-1];
    end
  end

  assign bclk_rise = pin_s2_r[SW-1] && !bclk_d_r;
  assign hs_s = pin_s2_r[8*NL-1:0];
  assign lp_s[NL] = pin_s2_r[SW-2 -: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // Lane count decode; other counts disable reception
  always_comb begin
    case (i_lane_cnt)
      3'h1: lane_act = 4'h1;
      3'h2: lane_act = 4'h3;
      3'h4: lane_act = 4'hF;
      default: lane_act = 4'h0;
    endcase
  end
  assign lane_num = (lane_act == '0) ? 3'h0 : i_lane_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Lane state machines, index NL is the clock lane
  for (genvar g = 0; g <= NL; g++) begin : g_lane
    crx_pkg::crx_lane_st_t st_r;
    if (g < NL) begin : g_lp
      assign lp_s[g] = {pin_s2_r[8*NL+NL+g], pin_s2_r[8*NL+g]};
    end
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        st_r <= crx_pkg::LS_INIT;
      end else begin
        case (st_r)
          crx_pkg::LS_INIT: if (lp_s[g] == crx_pkg::LP11) st_r <= crx_pkg::LS_STOP;
          // LP-10 would start escape; it is simply ignored
          crx_pkg::LS_STOP: if (lp_s[g] == crx_pkg::LP01) st_r <= crx_pkg::LS_RQST;
          crx_pkg::LS_RQST: begin
            if (lp_s[g] == crx_pkg::LP00) st_r <= crx_pkg::LS_HS;
            else if (lp_s[g] == crx_pkg::LP11) st_r <= crx_pkg::LS_STOP;
            else if (lp_s[g] == crx_pkg::LP10) st_r <= crx_pkg::LS_INIT;
          end
          // Sensor keeps LP-00 until it returns to stop
          crx_pkg::LS_HS: if (lp_s[g] == crx_pkg::LP11) st_r <= crx_pkg::LS_STOP;
          default: st_r <= crx_pkg::LS_INIT;
        endcase
      end
    end
    assign lane_hs_raw[g] = st_r == crx_pkg::LS_HS;
  end

  assign clk_hs = i_cont_clk || lane_hs_raw[NL];
  assign lane_rx = lane_hs_raw[NL-1:0] & lane_act & {NL{clk_hs}};
  assign o_term_en = lane_hs_raw[NL-1:0] & lane_act;
  assign o_clk_term_en = clk_hs;
  assign o_lane_hs = lane_rx;

  ////////////////////////////////////////////////////////////////////////////////
  // Sync byte check on the first byte of each burst; one bad bit is tolerated
  for (genvar g = 0; g < NL; g++) begin : g_sot
    logic seen_r;
    logic ok_r;
    logic [7:0] x;
    logic first;
    assign x = hs_s[8*g +: 8] ^ crx_pkg::SYNC_BYTE;
    assign first = lane_rx[g] && bclk_rise && !seen_r;
    always_ff @(posedge i_clk) begin
      if (i_rst || !lane_rx[g]) begin
        seen_r <= 1'b0;
        ok_r <= 1'b0;
      end else if (first) begin
        seen_r <= 1'b1;
        ok_r <= $countones(x) <= 1;
      end
    end
    assign sot_e[g] = first && $onehot(x);
    assign sync_e[g] = first && ($countones(x) > 1);
    assign lane_ok[g] = lane_rx[g] && ok_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte merge: lane 0 first, then upward; a stall past the next byte edge overflows
  logic [8*NL-1:0] hold_r;
  logic [2:0] left_r;
  logic [1:0] idx_r;
  logic cap;
  logic mb_valid;
  logic mb_fire;
  logic [7:0] mb_byte;
  logic ovf_nxt;
  logic pay_push;
  logic buf_in_ready;

  assign cap = bclk_rise && (lane_act != '0) && (&(lane_ok | ~lane_act));
  assign mb_valid = left_r != 3'h0;
  assign mb_byte = hold_r[8*idx_r +: 8];
  assign ovf_nxt = cap && (left_r > {2'h0, mb_fire});

  always_ff @(posedge i_clk) begin
    if (i_rst || !lane_rx[0]) begin
      hold_r <= '0;
      left_r <= 3'h0;
      idx_r <= 2'h0;
    end else if (cap) begin
      hold_r <= hs_s;
      left_r <= lane_num;
      idx_r <= 2'h0;
    end else if (mb_fire) begin
      left_r <= left_r - 3'h1;
      idx_r <= idx_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Packet parser
  crx_pkg::crx_pkt_st_t pst_r;
  logic [15:0] cnt_r;
  logic [23:0] hdr_r;
  logic [15:0] wc_r;
  logic [15:0] crc_r;
  logic [7:0] ftr_lo_r;
  logic frame_r;
  logic [5:0] syn;
  logic [23:0] hdr_fix;
  logic col_hit;
  logic hdr_bad;
  logic hdr_done;
  logic ftr_done;
  logic is_short;

  always_comb begin
    syn = ecc_calc(hdr_r) ^ mb_byte[5:0];
    hdr_fix = hdr_r;
    col_hit = 1'b0;
    for (int i = 0; i < 24; i++) begin
      if (syn == crx_pkg::ECC_COL[i]) begin
        hdr_fix[i] = ~hdr_r[i];
        col_hit = 1'b1;
      end
    end
  end

  assign hdr_bad = (syn != 6'h00) && !col_hit && !$onehot(syn);
  assign hdr_done = mb_fire && pst_r == crx_pkg::PS_HDR && cnt_r[1:0] == crx_pkg::HDR_LAST;
  assign ftr_done = mb_fire && pst_r == crx_pkg::PS_FTR && cnt_r[0];
  assign is_short = hdr_fix[5:0] <= crx_pkg::SHORT_DT_MAX;
  // Payload outside a frame is dropped rather than forwarded
  assign pay_push = mb_valid && pst_r == crx_pkg::PS_PAY && frame_r;
  assign mb_fire = mb_valid && (!(pst_r == crx_pkg::PS_PAY && frame_r) || buf_in_ready);

  always_ff @(posedge i_clk) begin
    if (i_rst || !lane_rx[0]) begin
      pst_r <= crx_pkg::PS_HDR;
      cnt_r <= 16'h0000;
      hdr_r <= 24'h000000;
      wc_r <= 16'h0000;
      crc_r <= crx_pkg::CRC_SEED;
      ftr_lo_r <= 8'h00;
    end else if (mb_fire) begin
      case (pst_r)
        crx_pkg::PS_HDR: begin
          if (cnt_r[1:0] == crx_pkg::HDR_LAST) begin
            cnt_r <= 16'h0000;
            wc_r <= hdr_fix[23:8];
            if (hdr_bad || is_short) pst_r <= crx_pkg::PS_SKIP;
            else if (hdr_fix[23:8] == 16'h0000) pst_r <= crx_pkg::PS_FTR;
            else pst_r <= crx_pkg::PS_PAY;
          end else begin
            hdr_r <= {mb_byte, hdr_r[23:8]};
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        crx_pkg::PS_PAY: begin
          crc_r <= crc_byte(crc_r, mb_byte);
          if (cnt_r == wc_r - 16'h0001) begin
            pst_r <= crx_pkg::PS_FTR;
            cnt_r <= 16'h0000;
          end else begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        crx_pkg::PS_FTR: begin
          if (!cnt_r[0]) begin
            ftr_lo_r <= mb_byte;
            cnt_r <= 16'h0001;
          end else begin
            pst_r <= crx_pkg::PS_SKIP;
          end
        end
        crx_pkg::PS_SKIP: pst_r <= crx_pkg::PS_SKIP;
        default: pst_r <= crx_pkg::PS_HDR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame tracking and status pulses
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      frame_r <= 1'b0;
      o_short_valid <= 1'b0;
      o_short_vc <= 2'h0;
      o_short_dt <= 6'h00;
      o_short_data <= 16'h0000;
    end else begin
      o_short_valid <= hdr_done && !hdr_bad && is_short;
      if (hdr_done && !hdr_bad && is_short) begin
        o_short_vc <= hdr_fix[7:6];
        o_short_dt <= hdr_fix[5:0];
        o_short_data <= hdr_fix[23:8];
        if (hdr_fix[5:0] == crx_pkg::DT_FS) frame_r <= 1'b1;
        if (hdr_fix[5:0] == crx_pkg::DT_FE) frame_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ecc_err <= 1'b0;
      o_ecc_corr <= 1'b0;
      o_crc_err <= 1'b0;
      o_sot_err <= 1'b0;
      o_sot_sync_err <= 1'b0;
      o_ovf <= 1'b0;
      o_cfg_err <= 1'b0;
    end else begin
      o_ecc_err <= hdr_done && syn != 6'h00;
      o_ecc_corr <= hdr_done && syn != 6'h00 && !hdr_bad;
      o_crc_err <= ftr_done && {mb_byte, ftr_lo_r} != crc_r;
      o_sot_err <= |sot_e;
      o_sot_sync_err <= |sync_e;
      o_ovf <= ovf_nxt;
      o_cfg_err <= lane_act == '0;
    end
  end

  assign o_in_frame = frame_r;

  crx_skid_buf #(.W(crx_pkg::BUF_W), .D(crx_pkg::BUF_D)) u_buf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_valid(pay_push),
    .o_ready(buf_in_ready),
    .i_data(mb_byte),
    .o_valid(o_valid),
    .i_ready(i_ready),
    .o_data(o_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_rqst_from_stop: assert property ($rose(g_lane[0].st_r == crx_pkg::LS_RQST) |->
    $past(g_lane[0].st_r) == crx_pkg::LS_STOP && $past(lp_s[0]) == crx_pkg::LP01)
    else $error("request state entered without stop then LP-01");
  a_hs_entry_seq: assert property ($rose(g_lane[0].st_r == crx_pkg::LS_HS) |->
    $past(g_lane[0].st_r) == crx_pkg::LS_RQST && $past(lp_s[0]) == crx_pkg::LP00)
    else $error("high-speed entered out of sequence");
  a_hs_until_stop: assert property (g_lane[0].st_r == crx_pkg::LS_HS && lp_s[0] != crx_pkg::LP11 |=>
    g_lane[0].st_r == crx_pkg::LS_HS)
    else $error("burst left without stop state");
  a_term_drop: assert property (g_lane[0].st_r == crx_pkg::LS_HS && lp_s[0] == crx_pkg::LP11 |=>
    !o_term_en[0])
    else $error("termination kept after burst end");
  a_clk_lane_seq: assert property ($rose(g_lane[NL].st_r == crx_pkg::LS_HS) |->
    $past(lp_s[NL]) == crx_pkg::LP00)
    else $error("clock lane entered high-speed out of sequence");
  a_cont_clk_hs: assert property (i_cont_clk && lane_hs_raw[0] && lane_act[0] |-> o_lane_hs[0])
    else $error("continuous clock did not enable reception");
  a_bad_lane_cnt: assert property (o_cfg_err && $past(o_cfg_err) |-> o_lane_hs == 4'h0)
    else $error("reception with invalid lane count");
  a_short_range: assert property (o_short_valid |-> o_short_dt <= crx_pkg::SHORT_DT_MAX)
    else $error("short packet with long data type");
  a_frame_start: assert property (o_short_valid && o_short_dt == crx_pkg::DT_FS |=>
    o_in_frame || $past(hdr_done))
    else $error("frame start not tracked");
  a_payload_len: assert property ($fell(pst_r == crx_pkg::PS_PAY) && pst_r == crx_pkg::PS_FTR |->
    $past(cnt_r) == wc_r - 16'h0001)
    else $error("payload length differs from word count");
  a_ecc_corr_flag: assert property (o_ecc_corr |-> o_ecc_err)
    else $error("correction without error flag");
  a_crc_after_ftr: assert property (o_crc_err |-> $past(pst_r) == crx_pkg::PS_FTR)
    else $error("checksum flag outside footer");
  a_sot_at_edge: assert property (o_sot_sync_err |-> $past(bclk_rise))
    else $error("sync error without byte edge");
  a_merge_order: assert property (mb_fire && left_r > 3'h1 && !cap |=> idx_r == $past(idx_r) + 2'h1)
    else $error("lane bytes merged out of order");

  c_short_pkt: cover property (o_short_valid);
  c_long_ok: cover property (ftr_done && {mb_byte, ftr_lo_r} == crc_r);
  c_stall: cover property (pay_push && !buf_in_ready);
  c_four_lane: cover property (cap && i_lane_cnt == 3'h4);
endmodule

// ---- design/crx_pkg.sv ----
// Constants and types shared by the camera lane receiver.
// Assumes one 40 MHz system clock; link pins are sampled, not clocked.
package crx_pkg;
  localparam int LANES = 4;
  // Low-power line states as {p, n}
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP00 = 2'h0;
  localparam logic [7:0] SYNC_BYTE = 8'hB8;
  localparam logic [5:0] SHORT_DT_MAX = 6'h0F;
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  // Syndrome column of each header bit, bit 23 first
  localparam logic [23:0][5:0] ECC_COL = {
    6'h3B, 6'h37, 6'h2F, 6'h1F, 6'h38, 6'h34, 6'h32, 6'h31,
    6'h2C, 6'h2A, 6'h29, 6'h26, 6'h25, 6'h23, 6'h1C, 6'h1A,
    6'h19, 6'h16, 6'h15, 6'h13, 6'h0E, 6'h0D, 6'h0B, 6'h07};
  localparam int BUF_W = 8;
  localparam int BUF_D = 2;
  typedef enum logic [1:0] {
    LS_INIT = 2'h2,
    LS_STOP = 2'h0,
    LS_RQST = 2'h1,
    LS_HS = 2'h3
  } crx_lane_st_t;
  typedef enum logic [1:0] {
    PS_HDR = 2'h0,
    PS_PAY = 2'h1,
    PS_FTR = 2'h3,
    PS_SKIP = 2'h2
  } crx_pkt_st_t;
endpackage

// ---- design/crx_skid_buf.sv ----
// Small FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module crx_skid_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic wr;
  logic rd;

  assign o_ready = cnt_r != (AW+1)'(D);
  assign o_valid = cnt_r != '0;
  assign o_data = mem_r[rp_r];
  assign wr = i_valid && o_ready;
  assign rd = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (wr) begin
      mem_r[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end
endmodule
